// ===== pkg/psfr_defines.vh
// Constants for the paged special function register decoder.
// Included by the decoder and its page map; definitions only.
`ifndef PSFR_DEFINES_VH
`define PSFR_DEFINES_VH

// Register space bounds
`define PSFR_SPACE_BASE 8'h80
`define PSFR_SPACE_TOP 8'hff
// Page selector
`define PSFR_PAGE_SELECT_ADDR 8'ha7
`define PSFR_PAGE_SELECT_RESET 8'h00
// Page numbers
`define PSFR_PAGE_ZERO 8'h00
`define PSFR_PAGE_F 8'h0f
// Bit-addressable low nibbles
`define PSFR_BIT_NIB_A 4'h0
`define PSFR_BIT_NIB_B 4'h8
// Target encodings of the page map
`define PSFR_MAP_NONE 2'h0
`define PSFR_MAP_PAGE0 2'h1
`define PSFR_MAP_PAGEF 2'h2
`define PSFR_MAP_ALL 2'h3

`endif

// ===== hw/psfr_page_map.v
// Occupancy map of the register space: for each of the 128 slots,
// whether it lives on page zero only, page F only, both, or nowhere.
// Assumes an 7-bit slot index from the decoder; answer is registered.
`timescale 1ns/1ps
`include "psfr_defines.vh"

module psfr_page_map
(
  input wire clk,
  input wire reset,
  input wire [6:0] slot,
  output reg [1:0] page0_kind,
  output reg [1:0] pagef_kind
)
;
  // ----------------------------------------
  // Map lookup
  // ----------------------------------------
  // Shared rows (one bit per slot): slot on every page
  localparam [127:0] ALL_MAP = 128'h00c1_00e1_0001_0000_1a00_0381_5401_00ff;
  // Page zero occupancy (shared slots included)
  localparam [127:0] P0_MAP = 128'hffff_ffff_ffff_ffff_ffef_ffff_ffff_ffff;
  // Page F occupancy (shared slots included)
  localparam [127:0] PF_MAP = 128'h00c9_00ed_4001_0000_1a20_0381_7e01_60ff;

  // Registered lookup for each page
  always @(posedge clk)
  begin
    if (reset)
    begin
      page0_kind <= `PSFR_MAP_NONE;
      pagef_kind <= `PSFR_MAP_NONE;
    end
    else
    begin
      page0_kind <= ALL_MAP[slot] ? `PSFR_MAP_ALL : (P0_MAP[slot] ? `PSFR_MAP_PAGE0 : `PSFR_MAP_NONE);
      pagef_kind <= ALL_MAP[slot] ? `PSFR_MAP_ALL : (PF_MAP[slot] ? `PSFR_MAP_PAGEF : `PSFR_MAP_NONE);
    end
  end
endmodule

// ===== hw/psfr_decoder.v
// Decoder for the direct-addressed special function register space.
// Assumes a core on the same clock presenting one access per strobe.
// A register access strobes the peripheral one cycle before it reports done,
// so the peripheral read data are taken while the peripheral is still selected.
// Reserved slots and refused bit accesses complete with a fault and zero data.
//
// Contract
// - Direct accesses to 0x80..0xff go to the register space, not data memory.
// - Addresses with low nibble 0x0 or 0x8 accept bit and byte access.
// - All other addresses accept byte access only.
// - After reset and while the selector is zero, accesses go to page zero.
// - A second page 0x0f holds registers reachable only while it is selected.
// - Some registers, the selector among them, decode the same on every page.
// - The selector is an 8-bit read/write register at 0xa7, on all pages, reset zero.
// - The selector picks the page for reads, writes and read-modify-writes.
// - Indirect accesses above 0x7f go to upper data memory, never registers.
`timescale 1ns/1ps
`include "psfr_defines.vh"

module psfr_decoder
(
  input wire clk,
  input wire reset,
  input wire acc_valid,
  input wire acc_write,
  input wire acc_rmw,
  input wire acc_indirect,
  input wire acc_bit,
  input wire [2:0] acc_bit_pos,
  input wire [7:0] acc_addr,
  input wire [7:0] acc_wdata,
  input wire [7:0] periph_rdata,
  output reg acc_done,
  output reg [7:0] acc_rdata,
  output reg acc_fault,
  output reg periph_sel,
  output reg periph_write,
  output reg periph_page_f,
  output reg [6:0] periph_slot,
  output reg [7:0] periph_wdata,
  output reg [7:0] periph_wmask,
  output reg ram_sel,
  output reg [7:0] register_page_select
)
;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Slot supports single-bit access
  function bit_capable;
    input [7:0] a;
    begin
      bit_capable = (a[3:0] == `PSFR_BIT_NIB_A) || (a[3:0] == `PSFR_BIT_NIB_B);
    end
  endfunction

  // One-hot lane mask for a bit position
  function [7:0] lane;
    input [2:0] p;
    begin
      lane = 8'h01 << p;
    end
  endfunction

  localparam ST_IDLE = 2'h0;
  localparam ST_LOOK = 2'h1;
  localparam ST_DO = 2'h2;

  reg [1:0] state;
  reg [7:0] hold_addr;
  reg [7:0] hold_wdata;
  reg hold_write;
  reg hold_bit;
  reg [2:0] hold_pos;
  reg page_f;
  wire [1:0] page0_kind;
  wire [1:0] pagef_kind;
  wire [1:0] kind;
  wire is_sel;
  wire bad_bit;
  wire [7:0] sel_merge;
  wire [6:0] map_slot;
  wire forward;

  // ----------------------------------------
  // Page map
  // ----------------------------------------
  // The map answers one cycle late, so while idle it looks up the address on
  // the bus; by the look-up step the answer for the taken request is ready and
  // the peripheral can be strobed a cycle before completion
  assign map_slot = (state == ST_IDLE) ? acc_addr[6:0] : hold_addr[6:0];

  psfr_page_map u_map
  (
    .clk(clk),
    .reset(reset),
    .slot(map_slot),
    .page0_kind(page0_kind),
    .pagef_kind(pagef_kind)
  );

  // ----------------------------------------
  // Access checks
  // ----------------------------------------
  // Page choice and per-access checks
  assign kind = page_f ? pagef_kind : page0_kind;
  assign is_sel = (hold_addr == `PSFR_PAGE_SELECT_ADDR);
  assign bad_bit = hold_bit && !bit_capable(hold_addr);
  // Only occupied slots with an allowed access width reach the peripherals
  assign forward = !is_sel && !bad_bit && (kind != `PSFR_MAP_NONE);
  assign sel_merge = hold_bit ? ((register_page_select & ~lane(hold_pos)) | (hold_wdata & lane(hold_pos)))
                              : hold_wdata;

  // ----------------------------------------
  // Access sequencer
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (reset)
    begin
      state <= ST_IDLE;
      hold_addr <= 8'h00;
      hold_wdata <= 8'h00;
      hold_write <= 1'b0;
      hold_bit <= 1'b0;
      hold_pos <= 3'h0;
      page_f <= 1'b0;
      register_page_select <= `PSFR_PAGE_SELECT_RESET;
      acc_done <= 1'b0;
      acc_rdata <= 8'h00;
      acc_fault <= 1'b0;
      periph_sel <= 1'b0;
      periph_write <= 1'b0;
      periph_page_f <= 1'b0;
      periph_slot <= 7'h00;
      periph_wdata <= 8'h00;
      periph_wmask <= 8'h00;
      ram_sel <= 1'b0;
    end
    else
    begin
      // Pulses drop unless a step below raises them
      acc_done <= 1'b0;
      periph_sel <= 1'b0;
      periph_write <= 1'b0;
      ram_sel <= 1'b0;
      // Page decision follows the selector; reserved values mean page zero
      page_f <= (register_page_select == `PSFR_PAGE_F);
      // Register access: take, look up and strobe, then complete
      case (state)
        ST_IDLE:
        begin
          if (acc_valid)
          begin
            if (acc_indirect || !acc_addr[7])
            begin
              // Data memory path: low half always, upper half only indirect
              ram_sel <= 1'b1;
              acc_done <= 1'b1;
              acc_fault <= 1'b0;
              acc_rdata <= 8'h00;
            end
            else
            begin
              // Register space: hold the request while the map looks it up
              hold_addr <= acc_addr;
              hold_wdata <= acc_wdata;
              hold_write <= acc_write | acc_rmw;
              hold_bit <= acc_bit;
              hold_pos <= acc_bit_pos;
              state <= ST_LOOK;
            end
          end
        end
        ST_LOOK:
        begin
          // Map answer for the held address is ready: strobe the peripheral on the
          // chosen page so its read data stand while it is selected
          // Nothing is strobed for the selector, a reserved slot or a refused bit access
          state <= ST_DO;
          if (forward)
          begin
            periph_sel <= 1'b1;
            periph_write <= hold_write; // Read-modify-write counts as a write
            periph_page_f <= page_f && (kind != `PSFR_MAP_ALL);
            periph_slot <= hold_addr[6:0];
            periph_wdata <= hold_wdata;
            periph_wmask <= hold_bit ? lane(hold_pos) : 8'hff;
          end
        end
        ST_DO:
        begin
          state <= ST_IDLE;
          acc_done <= 1'b1;
          // The selector is never reserved; anything else faults on an empty slot
          acc_fault <= bad_bit || (!is_sel && kind == `PSFR_MAP_NONE);
          if (is_sel && !bad_bit)
          begin
            // Selector decodes on every page and takes byte access only
            acc_rdata <= register_page_select;
            // Written as a whole byte; the next access sees the new page
            if (hold_write)
              register_page_select <= sel_merge;
          end
          else if (forward)
          begin
            // Peripheral still selected: old value, even for a read-modify-write
            acc_rdata <= hold_bit ? {7'h00, periph_rdata[hold_pos]} : periph_rdata;
          end
          else
          begin
            acc_rdata <= 8'h00; // Reserved slot or refused bit access
          end
        end
        default:
          state <= ST_IDLE;
      endcase
    end
  end
endmodule

// ===== test/psfr_periph_model.sv
// Peripheral registers behind the decoder, one byte per page and slot.
// Assumes the decoder presents slot, page and mask for a whole access.
`timescale 1ns/1ps
module psfr_periph_model
(
  input wire clk,
  input wire periph_sel,
  input wire periph_write,
  input wire periph_page_f,
  input wire [6:0] periph_slot,
  input wire [7:0] periph_wdata,
  input wire [7:0] periph_wmask,
  output wire [7:0] periph_rdata
);
  reg [7:0] mem [0:255];
  integer i;
  initial for (i = 0; i < 256; i = i + 1) mem[i] = 8'h00;
  // Deselected reads show the inverse, so a stale value never passes
  assign periph_rdata = periph_sel ? mem[{periph_page_f, periph_slot}] : ~mem[{periph_page_f, periph_slot}];
  // Masked write keeps the other bits of a bit write
  always @(posedge clk)
    if (periph_sel && periph_write) mem[{periph_page_f, periph_slot}] <= periph_wdata & periph_wmask
      | mem[{periph_page_f, periph_slot}] & ~periph_wmask;
endmodule

// ===== test/psfr_decoder_checker.sv
// Port assertions for the register space decoder.
// Bound to psfr_decoder; one clock, core holds a request one cycle.
`timescale 1ns/1ps
module psfr_checker
(
  input wire clk,
  input wire reset,
  input wire acc_valid,
  input wire acc_write,
  input wire acc_indirect,
  input wire acc_bit,
  input wire [7:0] acc_addr,
  input wire acc_done,
  input wire periph_sel,
  input wire periph_write,
  input wire periph_page_f,
  input wire [7:0] periph_wmask,
  input wire ram_sel,
  input wire [7:0] register_page_select
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Requests taken for the register space and for data memory
  sequence reg_take; acc_valid && !acc_indirect && acc_addr[7]; endsequence
  sequence ram_take; acc_valid && (acc_indirect || !acc_addr[7]); endsequence
  reg_route_a: assert property (reg_take |-> ##3 acc_done && !ram_sel) else $error("reg late");
  ram_route_a: assert property (ram_take |=> ram_sel && acc_done && !periph_sel) else $error("ram");
  sel_cause_a: assert property (periph_sel |-> $past(acc_addr[7], 2) && !$past(acc_indirect, 2)) else $error("sel");
  bit_cap_a: assert property (periph_sel && $past(acc_bit, 2) |-> $past(acc_addr[2:0], 2) == 3'h0) else $error("bit");
  byte_mask_a: assert property (periph_write && !$past(acc_bit, 2) |-> periph_wmask == 8'hff) else $error("mask");
  page_zero_a: assert property (periph_sel && register_page_select != 8'h0f |-> !periph_page_f) else $error("page zero");
  page_f_a: assert property (periph_sel && periph_page_f |-> register_page_select == 8'h0f) else $error("page");
  sel_reset_a: assert property ($past(reset) |-> register_page_select == 8'h00) else $error("reset");
  sel_change_a: assert property ($changed(register_page_select) |-> acc_done && $past(acc_write, 3)) else $error("pg");
endmodule
bind psfr_decoder psfr_checker chk (.*);

// ===== test/psfr_decoder_tb.sv
// Self-checking bench for the register space decoder.
// Core accesses are driven on the falling edge; a peripheral model answers.
`timescale 1ns/1ps
module psfr_decoder_tb;
  reg clk = 1'b0, reset = 1'b1, acc_valid = 0, acc_write = 0, acc_rmw = 0, acc_indirect = 0, acc_bit = 0;
  reg [2:0] acc_bit_pos = 0;
  reg [7:0] acc_addr = 0, acc_wdata = 0, got;
  reg flt, ram;
  wire [7:0] periph_rdata, acc_rdata, periph_wdata, periph_wmask, register_page_select;
  wire [6:0] periph_slot;
  wire acc_done, acc_fault, periph_sel, periph_write, periph_page_f, ram_sel;
  integer error_cnt = 0, n_checks = 0, k;
  // Clock
  always #12.5 clk = ~clk;
  psfr_decoder DUT (.*);
  psfr_periph_model partner (.*);
  task chk(input [7:0] seen, input [7:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // One access: strobe for one cycle, then wait for completion
  task acc(input wr, input rm, input id, input bi, input [2:0] pos, input [7:0] ad, input [7:0] wd);
    @(negedge clk);
    {acc_write, acc_rmw, acc_indirect, acc_bit, acc_bit_pos, acc_addr, acc_wdata} = {wr, rm, id, bi, pos, ad, wd};
    acc_valid = 1;
    @(negedge clk);
    acc_valid = 0;
    for (k = 0; k < 8 && acc_done !== 1'b1; k = k + 1)
      @(negedge clk);
    chk(acc_done, 8'h01);
    got = acc_rdata;
    flt = acc_fault;
    ram = ram_sel;
  endtask
  // Selector resets to zero and is reachable on page F
  task t_select;
    chk(register_page_select, 8'h00);
    acc(1, 0, 0, 0, 0, 8'ha7, 8'h0f);
    acc(0, 0, 0, 0, 0, 8'ha7, 8'h00);
    chk(got, 8'h0f);
    chk(flt, 8'h00);
  endtask
  // Slot 0x99 is a different register on each page
  task t_pages;
    acc(1, 0, 0, 0, 0, 8'h99, 8'h5a);
    acc(1, 0, 0, 0, 0, 8'ha7, 8'h00);
    acc(1, 0, 0, 0, 0, 8'h99, 8'h33);
    acc(1, 0, 0, 0, 0, 8'ha7, 8'h05);
    acc(0, 0, 0, 0, 0, 8'h99, 8'h00);
    chk(got, 8'h33);
    acc(1, 0, 0, 0, 0, 8'ha7, 8'h0f);
    acc(0, 1, 0, 0, 0, 8'h99, 8'h11);
    chk(got, 8'h5a);
    acc(0, 0, 0, 0, 0, 8'h99, 8'h00);
    chk(got, 8'h11);
    acc(1, 0, 0, 0, 0, 8'ha7, 8'h00);
    acc(0, 0, 0, 0, 0, 8'h99, 8'h00);
    chk(got, 8'h33);
  endtask
  // Bit access, refused bit access and a reserved slot
  task t_bits;
    acc(1, 0, 0, 1, 3'h3, 8'ha0, 8'h08);
    acc(0, 0, 0, 0, 0, 8'ha0, 8'h00);
    chk(got, 8'h08);
    acc(0, 0, 0, 1, 3'h3, 8'ha0, 8'h00);
    chk(got, 8'h01);
    acc(0, 0, 0, 1, 3'h1, 8'ha1, 8'h00);
    chk(flt, 8'h01);
    acc(0, 0, 0, 0, 0, 8'hb4, 8'h00);
    chk({flt, got[6:0]}, 8'h80);
  endtask
  // Indirect upper addresses go to data memory, direct ones do not
  task t_ram;
    acc(0, 0, 1, 0, 0, 8'hc0, 8'h00);
    chk(ram, 8'h01);
    acc(0, 0, 0, 0, 0, 8'hc0, 8'h00);
    chk({ram, flt}, 8'h00);
  endtask
  initial
  begin
    repeat (5) @(negedge clk);
    reset = 0;
    t_select;
    t_pages;
    t_bits;
    t_ram;
    acc(1, 0, 0, 0, 0, 8'ha7, 8'h0f);
    chk(register_page_select, 8'h0f);
    reset = 1;
    repeat (5) @(negedge clk);
    reset = 0;
    chk(register_page_select, 8'h00);
    acc(0, 0, 0, 0, 0, 8'h99, 8'h00);
    chk(got, 8'h33);
    end_sim;
  end
  // Watchdog
  initial
  begin
    #100000;
    error_cnt = error_cnt + 1;
    end_sim;
  end
endmodule
